// File: dv/fabric_source.sv
// Fabric-side source of operands and per-cycle controls for the multiply tile.
// Assumes the tile shares i_clk; every output moves just after a rising edge.
`timescale 1ns/10ps
module fabric_source (
	// Clock and reset.
	input  wire logic                              i_clk,
	input  wire logic                              i_resetn,
	// Stream control from the bench.
	input  wire logic                              i_run,
	// Operands and per-cycle controls towards the tile.
	output logic                                   o_valid,
	output logic      [dsp_mac_pkg::OPERAND_W-1:0] o_a,
	output logic      [dsp_mac_pkg::OPERAND_W-1:0] o_b,
	output logic      [dsp_mac_pkg::SHIFT_W-1:0]   o_shift_in_a,
	output logic      [dsp_mac_pkg::SHIFT_W-1:0]   o_shift_in_b,
	output logic                                   o_a_signed,
	output logic                                   o_b_signed,
	output logic                                   o_subtract,
	output logic                                   o_shift
);
	import dsp_mac_pkg::*;

	logic [31:0]  seed_reg;
	logic [31:0]  s;
	logic [255:0] pool;

	// Galois shift register, advanced 32 steps per call.
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		for (int k = 0; k < 32; k++) begin
			v = v[0] ? ((v >> 1) ^ 32'h80200003) : (v >> 1);
		end
		return v;
	endfunction

	// Quiet state used at time zero and during reset.
	task automatic idle();
		seed_reg <= 32'h66030385;
		o_valid <= 1'b0;
		o_a <= '0;
		o_b <= '0;
		o_shift_in_a <= '0;
		o_shift_in_b <= '0;
		o_a_signed <= 1'b0;
		o_b_signed <= 1'b0;
		o_subtract <= 1'b0;
		o_shift <= 1'b0;
	endtask

	initial idle();

	////////////////////////////////////////////////////////////////////////////////
	// Fresh random operands every cycle, so idle lines are redrawn each cycle instead of holding old values.
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			idle();
		end else begin
			s = seed_reg;
			for (int k = 0; k < 8; k++) begin
				s = lfsr(s);
				pool[32*k +: 32] = s;
			end
			seed_reg <= s;
			o_valid <= i_run & (pool[0] | pool[1]);
			o_a <= pool[71:0];
			o_b <= pool[143:72];
			o_shift_in_a <= pool[179:144];
			o_shift_in_b <= pool[215:180];
			o_a_signed <= pool[216];
			o_b_signed <= pool[217];
			o_subtract <= pool[218];
			o_shift <= pool[219];
		end
	end
endmodule // fabric_source

// File: dv/testbench.sv
// Self-checking bench for the multiply tile: register port, all styles and widths, clears.
// Assumes the fabric source drives operands; a reference model predicts every result.
`timescale 1ns/10ps
module testbench;
	import dsp_mac_pkg::*;

	logic                 i_clk;
	logic                 i_resetn;
	logic                 i_clear;
	logic [ADDR_W-1:0]    i_addr;
	logic [DATA_W-1:0]    i_wdata;
	logic                 i_wr;
	logic                 i_rd;
	logic [DATA_W-1:0]    o_rdata;
	logic                 i_valid;
	logic [OPERAND_W-1:0] i_a;
	logic [OPERAND_W-1:0] i_b;
	logic [SHIFT_W-1:0]   i_shift_in_a;
	logic [SHIFT_W-1:0]   i_shift_in_b;
	logic                 i_a_signed;
	logic                 i_b_signed;
	logic                 i_subtract;
	logic                 i_shift;
	logic [RESULT_W-1:0]  o_result;
	logic                 o_valid;
	logic                 run;
	int                   n_fail;
	int                   n_tests;
	logic [8:0]           cfg;
	logic [71:0]          opa;
	logic [71:0]          opb;
	logic [71:0]          acc0;
	logic [71:0]          acc1;
	logic [71:0]          t0;
	logic [71:0]          t1;
	logic [71:0]          p [8];
	logic [143:0]         qr [3];
	logic [143:0]         r;
	logic [143:0]         last_r;
	logic [2:0]           qv;
	logic                 rd_seen;
	logic                 rd_valid;
	logic                 sa, sb, su, sh;
	int                   w;
	int                   n;
	logic [31:0]          d;

	dsp_multiply_accumulate_block dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_clear(i_clear), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_valid(i_valid), .i_a(i_a), .i_b(i_b),
		.i_shift_in_a(i_shift_in_a), .i_shift_in_b(i_shift_in_b), .i_a_signed(i_a_signed),
		.i_b_signed(i_b_signed), .i_subtract(i_subtract), .i_shift(i_shift), .o_result(o_result), .o_valid(o_valid));

	fabric_source src (.i_clk(i_clk), .i_resetn(i_resetn), .i_run(run), .o_valid(i_valid), .o_a(i_a), .o_b(i_b),
		.o_shift_in_a(i_shift_in_a), .o_shift_in_b(i_shift_in_b), .o_a_signed(i_a_signed),
		.o_b_signed(i_b_signed), .o_subtract(i_subtract), .o_shift(i_shift));

	always #25 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [71:0] ext(input logic [71:0] v, input int wd, input logic sg);
		logic [71:0] m;
		m = (72'h1 << wd) - 72'h1;
		return (sg && v[wd-1]) ? (v | ~m) : (v & m);
	endfunction

	function automatic int count_of(input logic [1:0] s, input logic [1:0] wd);
		int t [4][3];
		t = '{'{8, 4, 1}, '{2, 2, 0}, '{4, 2, 0}, '{2, 1, 0}};
		return (wd == 2'h3) ? 0 : t[s][wd];
	endfunction

	// Reference model: result of each sampling edge, delivered two edges later.
	always @(posedge i_clk or negedge i_resetn) begin
		rd_seen = i_rd & i_resetn;
		if (i_rd) rd_valid = qv[2];
		if (!i_resetn || i_clear) begin
			opa = '0;
			opb = '0;
			acc0 = '0;
			acc1 = '0;
			qv = '0;
			qr = '{default: '0};
			last_r = '0;
		end else begin
			sa = cfg[4] ? i_a_signed : cfg[5];
			sb = cfg[4] ? i_b_signed : cfg[6];
			su = cfg[4] ? i_subtract : cfg[7];
			sh = cfg[4] ? i_shift : cfg[8];
			w = (cfg[3:2] == 2'h0) ? 9 : (cfg[3:2] == 2'h1) ? 18 : 36;
			n = count_of(cfg[1:0], cfg[3:2]);
			if (sh) begin
				opa = (opa << w) | ({36'h0, i_shift_in_a} & ((72'h1 << w) - 72'h1));
				opb = (opb << w) | ({36'h0, i_shift_in_b} & ((72'h1 << w) - 72'h1));
			end else begin
				opa = i_a;
				opb = i_b;
			end
			r = '0;
			for (int k = 0; k < 8; k++) begin
				p[k] = (k < n) ? ext(opa >> (w * k), w, sa) * ext(opb >> (w * k), w, sb) : 72'h0;
				r = r | (({72'h0, p[k]} & ((144'h1 << (2 * w)) - 144'h1)) << (2 * w * k));
			end
			t0 = su ? p[0] - p[1] : p[0] + p[1];
			t1 = su ? p[2] - p[3] : p[2] + p[3];
			if (i_valid && cfg[1:0] == 2'h1) begin
				acc0 = su ? acc0 - p[0] : acc0 + p[0];
				acc1 = su ? acc1 - p[1] : acc1 + p[1];
			end
			if (i_valid && cfg[1:0] == 2'h3) acc0 = acc0 + t0;
			if (cfg[1:0] == 2'h1) r = {acc1, acc0};
			if (cfg[1:0] == 2'h2) r = {t1, t0};
			if (cfg[1:0] == 2'h3) r = {72'h0, acc0};
			qr[2] = qr[1];
			qr[1] = qr[0];
			qr[0] = r;
			qv = {qv[1:0], i_valid};
			if (qv[2]) last_r = qr[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_res(input string what, input logic [143:0] e, input logic [143:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_reg(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_flag(input string what, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %b seen %b", what, e, g);
		end
	endtask

	always @(negedge i_clk) begin
		if (!i_resetn) begin
			chk_res("reset result", '0, o_result);
			chk_flag("reset valid", 1'b0, o_valid);
		end else begin
			chk_flag("o_valid", qv[2], o_valid);
			chk_res("o_result", last_r, o_result);
		end
		if (rd_seen !== 1'b1) chk_reg("idle rdata", '0, o_rdata);
	end

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		if (a == ADDR_CONFIG) cfg <= v[8:0];
		@(posedge i_clk);
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		v = o_rdata;
		@(posedge i_clk);
	endtask

	// Configure, clear, stream with a clear in mid-run, then drain.
	task automatic run_stream(input logic [8:0] c, input string name);
		reg_wr(ADDR_CONFIG, {23'h0, c});
		i_clear <= 1'b1;
		@(posedge i_clk);
		i_clear <= 1'b0;
		run <= 1'b1;
		repeat (20) @(posedge i_clk);
		reg_rd(ADDR_STATUS, d);
		chk_reg("stream status", {27'h0, rd_valid, 4'(count_of(c[1:0], c[3:2]))}, d);
		i_clear <= 1'b1;
		@(posedge i_clk);
		i_clear <= 1'b0;
		repeat (20) @(posedge i_clk);
		run <= 1'b0;
		repeat (5) @(posedge i_clk);
		$display("test %s %h done", name, c);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		i_resetn = 1'b0;
		i_clear = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		run = 1'b0;
		cfg = 9'h000;
		n_fail = 0;
		n_tests = 0;
		repeat (2) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		reg_rd(ADDR_CONFIG, d);
		chk_reg("config reset", 32'h0, d);
		reg_rd(ADDR_STATUS, d);
		chk_reg("status reset", 32'h8, d);
		reg_wr(ADDR_CONFIG, 32'hffffffff);
		reg_wr(ADDR_STATUS, 32'h0);
		reg_wr(4'h8, 32'h0);
		reg_rd(ADDR_CONFIG, d);
		chk_reg("config bits", 32'h1ff, d);
		reg_rd(4'hc, d);
		chk_reg("unmapped read", 32'h0, d);
		$display("test registers done");
		for (int k = 0; k < 16; k++) begin
			reg_wr(ADDR_CONFIG, 32'(k));
			reg_rd(ADDR_STATUS, d);
			chk_reg("status count", 32'(count_of(k[1:0], k[3:2])), d);
		end
		$display("test element counts done");
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < 3; k++) begin
				run_stream(9'h010 | 9'(k << 2) | 9'(s), "dynamic");
			end
		end
		run_stream(9'h0a6, "static add_sub");
		run_stream(9'h1e1, "static accumulate");
		results();
	end

	initial begin
		repeat (5000) @(posedge i_clk);
		n_fail++;
		$display("ERROR watchdog expected end seen running");
		results();
	end
endmodule // testbench

// File: logic/dsp_mac_pkg.sv
// Constants, types and shared decoding for the multiply-accumulate tile.
// Assumes a single fabric clock and an asynchronous active-low reset.
package dsp_mac_pkg;

	typedef enum logic [1:0] {
		STYLE_MULTIPLY_ONLY        = 2'h0,
		STYLE_MULTIPLY_ACCUMULATE  = 2'h1,
		STYLE_MULTIPLY_ADD_SUB     = 2'h2,
		STYLE_MULTIPLY_ADD_SUB_SUM = 2'h3
	} style_t;

	typedef enum logic [1:0] {
		WIDTH_X9  = 2'h0,
		WIDTH_X18 = 2'h1,
		WIDTH_X36 = 2'h2
	} width_t;

	localparam int OPERAND_W = 72;
	localparam int RESULT_W  = 144;
	localparam int ACC_W     = 72;
	localparam int SHIFT_W   = 36;
	localparam int ADDR_W    = 4;
	localparam int DATA_W    = 32;

	localparam logic [3:0] ADDR_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;

	localparam int CFG_W            = 9;
	localparam int CFG_STYLE_LSB    = 0;
	localparam int CFG_WIDTH_LSB    = 2;
	localparam int CFG_DYNAMIC_BIT  = 4;
	localparam int CFG_A_SIGNED_BIT = 5;
	localparam int CFG_B_SIGNED_BIT = 6;
	localparam int CFG_SUBTRACT_BIT = 7;
	localparam int CFG_SHIFT_BIT    = 8;
	localparam logic [8:0] CONFIG_RESET = 9'h000;

	localparam int STAT_COUNT_LSB = 0;
	localparam int STAT_VALID_BIT = 4;

	// Number of usable elements for a style and operand width.
	function automatic logic [3:0] elem_count(input style_t s, input width_t w);
		logic [3:0] n;
		n = 4'h0;
		case (s)
			STYLE_MULTIPLY_ONLY: begin
				n = (w == WIDTH_X9) ? 4'h8 : (w == WIDTH_X18) ? 4'h4 : (w == WIDTH_X36) ? 4'h1 : 4'h0;
			end
			STYLE_MULTIPLY_ACCUMULATE: begin
				n = (w == WIDTH_X9 || w == WIDTH_X18) ? 4'h2 : 4'h0;
			end
			STYLE_MULTIPLY_ADD_SUB: begin
				n = (w == WIDTH_X9) ? 4'h4 : (w == WIDTH_X18) ? 4'h2 : 4'h0;
			end
			STYLE_MULTIPLY_ADD_SUB_SUM: begin
				n = (w == WIDTH_X9) ? 4'h2 : (w == WIDTH_X18) ? 4'h1 : 4'h0;
			end
			default: begin
				n = 4'h0;
			end
		endcase
		return n;
	endfunction

endpackage

// File: logic/dsp_multiply_accumulate_block.sv
// Multiply tile: operand registers, multipliers, pipeline and output stage.
// Assumes user fabric logic drives operands and controls on i_clk.
//
// What this block does
// - Offers multiply, multiply-accumulate, multiply add/sub and add/sub with summation.
// - Operand width selects 9, 18 or 36 bits per element.
// - Usable element count follows style and width; unused elements produce zero.
// - Operand registers load in parallel or shift from the preceding element.
// - In dynamic mode operands switch signed or unsigned every cycle.
// - In dynamic mode add or subtract may change every cycle.
// - In dynamic mode loading switches between parallel and shift chain.
// - Three register stages: operand input, post-multiply pipeline, output.
// - The add/subtract control has its own input register aligned with operands.
`timescale 1ns/10ps
module dsp_multiply_accumulate_block (
	// Clock and reset.
	input  wire logic                               i_clk,
	input  wire logic                               i_resetn,
	input  wire logic                               i_clear,
	// Register port.
	input  wire logic [dsp_mac_pkg::ADDR_W-1:0]     i_addr,
	input  wire logic [dsp_mac_pkg::DATA_W-1:0]     i_wdata,
	input  wire logic                               i_wr,
	input  wire logic                               i_rd,
	output logic      [dsp_mac_pkg::DATA_W-1:0]     o_rdata,
	// Operands and per-cycle controls.
	input  wire logic                               i_valid,
	input  wire logic [dsp_mac_pkg::OPERAND_W-1:0]  i_a,
	input  wire logic [dsp_mac_pkg::OPERAND_W-1:0]  i_b,
	input  wire logic [dsp_mac_pkg::SHIFT_W-1:0]    i_shift_in_a,
	input  wire logic [dsp_mac_pkg::SHIFT_W-1:0]    i_shift_in_b,
	input  wire logic                               i_a_signed,
	input  wire logic                               i_b_signed,
	input  wire logic                               i_subtract,
	input  wire logic                               i_shift,
	// Result.
	output logic      [dsp_mac_pkg::RESULT_W-1:0]   o_result,
	output logic                                    o_valid
);
	import dsp_mac_pkg::*;

	typedef struct packed {
		logic [CFG_W-1:0]    cfg;
		logic [DATA_W-1:0]   rdata;
		logic                a_signed;
		logic                b_signed;
		logic                subtract;
		logic                valid_r;
		logic                prod_signed;
		logic                subtract_p;
		logic                valid_p;
		logic [RESULT_W-1:0] result;
		logic                valid_o;
	} core_t;

	core_t                 st_reg;
	core_t                 st_next;
	style_t                style;
	width_t                width;
	logic                  dynamic;
	logic                  sel_a_signed;
	logic                  sel_b_signed;
	logic                  sel_sub;
	logic                  sel_shift;
	logic [3:0]            count;
	logic [OPERAND_W-1:0]  a_q;
	logic [OPERAND_W-1:0]  b_q;
	logic [RESULT_W-1:0]   p9_all;
	logic [RESULT_W-1:0]   p18_all;
	logic [ACC_W-1:0]      p36;
	logic [3:0][ACC_W-1:0] prod;
	logic [ACC_W-1:0]      pair_lo;
	logic [ACC_W-1:0]      pair_hi;

	////////////////////////////////////////////////////////////////////////////

	// Extend a raw product to accumulator width, sign-extending only when s is set.
	function automatic logic [ACC_W-1:0] ext_prod(input logic [ACC_W-1:0] p, input width_t w, input logic s);
		logic [ACC_W-1:0] e;
		e = p;
		case (w)
			WIDTH_X9: begin
				e = s ? {{54{p[17]}}, p[17:0]} : {54'h0, p[17:0]};
			end
			WIDTH_X18: begin
				e = s ? {{36{p[35]}}, p[35:0]} : {36'h0, p[35:0]};
			end
			default: begin
				e = p;
			end
		endcase
		return e;
	endfunction

	// Add or subtract one term.
	function automatic logic [ACC_W-1:0] add_sub(input logic [ACC_W-1:0] x, input logic [ACC_W-1:0] y,
			input logic sub);
		return sub ? x - y : x + y;
	endfunction

	////////////////////////////////////////////////////////////////////////////

	assign style = style_t'(st_reg.cfg[CFG_STYLE_LSB +: 2]);
	assign width = width_t'(st_reg.cfg[CFG_WIDTH_LSB +: 2]);
	assign dynamic = st_reg.cfg[CFG_DYNAMIC_BIT];
	assign sel_a_signed = dynamic ? i_a_signed : st_reg.cfg[CFG_A_SIGNED_BIT];
	assign sel_b_signed = dynamic ? i_b_signed : st_reg.cfg[CFG_B_SIGNED_BIT];
	assign sel_sub = dynamic ? i_subtract : st_reg.cfg[CFG_SUBTRACT_BIT];
	assign sel_shift = dynamic ? i_shift : st_reg.cfg[CFG_SHIFT_BIT];
	assign count = elem_count(style, width);

	operand_chain u_chain_a (
		.i_clk      (i_clk),
		.i_resetn   (i_resetn),
		.i_clear    (i_clear),
		.i_shift    (sel_shift),
		.i_width    (width),
		.i_par      (i_a),
		.i_shift_in (i_shift_in_a),
		.o_q        (a_q)
	);

	operand_chain u_chain_b (
		.i_clk      (i_clk),
		.i_resetn   (i_resetn),
		.i_clear    (i_clear),
		.i_shift    (sel_shift),
		.i_width    (width),
		.i_par      (i_b),
		.i_shift_in (i_shift_in_b),
		.o_q        (b_q)
	);

	////////////////////////////////////////////////////////////////////////////

	for (genvar k = 0; k < 8; k++) begin : g_x9
		product_lane #(.W(9)) u_lane (
			.i_clk      (i_clk),
			.i_resetn   (i_resetn),
			.i_clear    (i_clear),
			.i_en       (width == WIDTH_X9 && count > 4'(k)),
			.i_a        (a_q[9*k +: 9]),
			.i_b        (b_q[9*k +: 9]),
			.i_a_signed (st_reg.a_signed),
			.i_b_signed (st_reg.b_signed),
			.o_p        (p9_all[18*k +: 18])
		);
	end

	for (genvar k = 0; k < 4; k++) begin : g_x18
		product_lane #(.W(18)) u_lane (
			.i_clk      (i_clk),
			.i_resetn   (i_resetn),
			.i_clear    (i_clear),
			.i_en       (width == WIDTH_X18 && count > 4'(k)),
			.i_a        (a_q[18*k +: 18]),
			.i_b        (b_q[18*k +: 18]),
			.i_a_signed (st_reg.a_signed),
			.i_b_signed (st_reg.b_signed),
			.o_p        (p18_all[36*k +: 36])
		);
	end

	product_lane #(.W(36)) u_lane_x36 (
		.i_clk      (i_clk),
		.i_resetn   (i_resetn),
		.i_clear    (i_clear),
		.i_en       (width == WIDTH_X36 && count != 4'h0),
		.i_a        (a_q[35:0]),
		.i_b        (b_q[35:0]),
		.i_a_signed (st_reg.a_signed),
		.i_b_signed (st_reg.b_signed),
		.o_p        (p36)
	);

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		for (int k = 0; k < 4; k++) begin
			prod[k] = ext_prod(width == WIDTH_X9 ? {54'h0, p9_all[18*k +: 18]} :
				width == WIDTH_X18 ? {36'h0, p18_all[36*k +: 36]} : (k == 0 ? p36 : 72'h0),
				width, st_reg.prod_signed);
		end
		pair_lo = add_sub(prod[0], prod[1], st_reg.subtract_p);
		pair_hi = add_sub(prod[2], prod[3], st_reg.subtract_p);
	end

	always_comb begin
		st_next = st_reg;
		st_next.rdata = '0;
		if (i_wr && i_addr == ADDR_CONFIG) begin
			st_next.cfg = i_wdata[CFG_W-1:0];
		end
		if (i_rd) begin
			case (i_addr)
				ADDR_CONFIG: begin
					st_next.rdata = {23'h0, st_reg.cfg};
				end
				ADDR_STATUS: begin
					st_next.rdata = {27'h0, st_reg.valid_o, count};
				end
				default: begin
					st_next.rdata = '0;
				end
			endcase
		end
		st_next.a_signed = sel_a_signed;
		st_next.b_signed = sel_b_signed;
		st_next.subtract = sel_sub;
		st_next.valid_r = i_valid;
		st_next.prod_signed = st_reg.a_signed | st_reg.b_signed;
		st_next.subtract_p = st_reg.subtract;
		st_next.valid_p = st_reg.valid_r;
		st_next.valid_o = st_reg.valid_p;
		if (st_reg.valid_p) begin
			case (style)
				STYLE_MULTIPLY_ONLY: begin
					st_next.result = width == WIDTH_X9 ? p9_all : width == WIDTH_X18 ? p18_all : {72'h0, p36};
				end
				STYLE_MULTIPLY_ACCUMULATE: begin
					st_next.result = {add_sub(st_reg.result[143:72], prod[1], st_reg.subtract_p),
						add_sub(st_reg.result[71:0], prod[0], st_reg.subtract_p)};
				end
				STYLE_MULTIPLY_ADD_SUB: begin
					st_next.result = {pair_hi, pair_lo};
				end
				STYLE_MULTIPLY_ADD_SUB_SUM: begin
					st_next.result = {72'h0, st_reg.result[71:0] + pair_lo};
				end
				default: begin
					st_next.result = st_reg.result;
				end
			endcase
		end
		if (i_clear) begin
			st_next.a_signed = 1'b0;
			st_next.b_signed = 1'b0;
			st_next.subtract = 1'b0;
			st_next.valid_r = 1'b0;
			st_next.prod_signed = 1'b0;
			st_next.subtract_p = 1'b0;
			st_next.valid_p = 1'b0;
			st_next.result = '0;
			st_next.valid_o = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg <= '{cfg: CONFIG_RESET, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rdata = st_reg.rdata;
	assign o_result = st_reg.result;
	assign o_valid = st_reg.valid_o;

	////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	a_style_add_subtract_control: assert property (
		style == STYLE_MULTIPLY_ADD_SUB && st_reg.valid_p && st_reg.subtract_p && !i_clear && !i_wr
		|=> o_result[71:0] == $past(prod[0]) - $past(prod[1])) else $error("Add/sub style result wrong.");

	a_x36_upper: assert property (
		style == STYLE_MULTIPLY_ONLY && width == WIDTH_X36 && st_reg.valid_p && !i_clear && !i_wr
		|=> o_result[143:72] == 72'h0 && o_result[71:0] == $past(p36)) else $error("Wide product misplaced.");

	a_lane_mask: assert property (
		width == WIDTH_X9 && count < 4'h8 && !i_wr |=> p9_all[143:126] == 18'h0)
		else $error("Unused element produced a product.");

	a_shift_chain: assert property (
		dynamic && i_shift && width == WIDTH_X9 && !i_clear && !i_wr
		|=> a_q[17:9] == $past(a_q[8:0]) && a_q[8:0] == $past(i_shift_in_a[8:0])) else $error("Shift chain broken.");

	a_sign_align: assert property (
		(dynamic && i_a_signed && !i_clear && !i_wr ##1 !i_clear) |=> st_reg.prod_signed)
		else $error("Signed control misaligned.");

	a_subtract_align: assert property (
		(dynamic && i_subtract && i_valid && !i_clear && !i_wr ##1 !i_clear) |=> st_reg.subtract_p && st_reg.valid_p)
		else $error("Subtract control misaligned.");

	a_parallel_load: assert property (
		dynamic && !i_shift && !i_clear && !i_wr |=> a_q == $past(i_a) && b_q == $past(i_b))
		else $error("Parallel load failed.");

	a_stage_depth: assert property (
		(i_valid && !i_clear ##1 !i_clear [*2]) |=> o_valid) else $error("Result not after three stages.");

	a_subtract_reg: assert property (
		i_valid && !i_clear |=> st_reg.valid_r && st_reg.subtract == $past(sel_sub))
		else $error("Subtract register not captured.");

	a_mac_add: assert property (
		style == STYLE_MULTIPLY_ACCUMULATE && st_reg.valid_p && !st_reg.subtract_p && !i_clear && !i_wr
		|=> o_result[71:0] == $past(o_result[71:0]) + $past(prod[0])) else $error("Accumulate step wrong.");

	a_clear_all: assert property (
		i_clear |=> o_result == '0 && !o_valid && a_q == '0 && b_q == '0 && !st_reg.valid_p)
		else $error("Clear left state behind.");

	c_mac_subtract: cover property (style == STYLE_MULTIPLY_ACCUMULATE && st_reg.valid_p && st_reg.subtract_p);
	c_shift_x18: cover property (dynamic && i_shift && width == WIDTH_X18 ##1 !i_shift);
	c_sum_style: cover property (style == STYLE_MULTIPLY_ADD_SUB_SUM && st_reg.valid_p ##1 st_reg.valid_p);

endmodule // dsp_multiply_accumulate_block

// File: logic/operand_chain.sv
// Operand input register with parallel load or shift-chain load.
// Assumes the shift control and width are synchronous to i_clk.
`timescale 1ns/10ps
module operand_chain (
	// Clock and reset.
	input  wire logic                           i_clk,
	input  wire logic                           i_resetn,
	input  wire logic                           i_clear,
	// Load control.
	input  wire logic                           i_shift,
	input  wire dsp_mac_pkg::width_t            i_width,
	// Operand data.
	input  wire logic [dsp_mac_pkg::OPERAND_W-1:0] i_par,
	input  wire logic [dsp_mac_pkg::SHIFT_W-1:0]   i_shift_in,
	output logic      [dsp_mac_pkg::OPERAND_W-1:0] o_q
);
	import dsp_mac_pkg::*;

	typedef struct packed {
		logic [OPERAND_W-1:0] q;
	} chain_t;

	chain_t st_reg;
	chain_t st_next;

	// At 9 and 18 bits each element takes the one below it; element zero takes the chain input.
	always_comb begin
		st_next = st_reg;
		if (i_clear) begin
			st_next.q = '0;
		end else if (i_shift) begin
			case (i_width)
				WIDTH_X9: begin
					st_next.q = {st_reg.q[62:0], i_shift_in[8:0]};
				end
				WIDTH_X18: begin
					st_next.q = {st_reg.q[53:0], i_shift_in[17:0]};
				end
				default: begin
					st_next.q = {36'h0, i_shift_in};
				end
			endcase
		end else begin
			st_next.q = i_par;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_q = st_reg.q;

endmodule // operand_chain

// File: logic/product_lane.sv
// One multiplier element followed by its pipeline register.
// Assumes operands come straight from the operand input registers.
`timescale 1ns/10ps
module product_lane #(
	parameter int W = 9
) (
	// Clock and reset.
	input  wire logic           i_clk,
	input  wire logic           i_resetn,
	input  wire logic           i_clear,
	// Element enable and operands.
	input  wire logic           i_en,
	input  wire logic [W-1:0]   i_a,
	input  wire logic [W-1:0]   i_b,
	input  wire logic           i_a_signed,
	input  wire logic           i_b_signed,
	// Registered product.
	output logic      [2*W-1:0] o_p
);
	import dsp_mac_pkg::*;

	typedef struct packed {
		logic [2*W-1:0] p;
	} lane_t;

	lane_t                 st_reg;
	lane_t                 st_next;
	logic signed [W:0]     ax;
	logic signed [W:0]     bx;
	logic signed [2*W+1:0] full;

	// An extra top bit carries the sign so unsigned operands stay positive.
	always_comb begin
		ax = $signed({i_a_signed & i_a[W-1], i_a});
		bx = $signed({i_b_signed & i_b[W-1], i_b});
		full = ax * bx;
		st_next = st_reg;
		st_next.p = (i_clear || !i_en) ? '0 : full[2*W-1:0];
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_p = st_reg.p;

endmodule // product_lane
